/* File: logic/ext_scale_position_monitor_consts.vh */
// constants for the external scale position monitor: offsets, fields, codes
// assumes a 32-bit avalon-mm slave with byte addresses on a 100 mhz clock
`ifndef EXT_SCALE_POSITION_MONITOR_CONSTS_VH
`define EXT_SCALE_POSITION_MONITOR_CONSTS_VH
// register byte offsets
`define OFS_NET_EXT_SETUP 6'h00
`define OFS_SCALE_CONFIG 6'h04
`define OFS_IRQ_STATUS 6'h08
`define OFS_IRQ_MASK 6'h0C
`define OFS_SCALE_POS 6'h10
`define OFS_COMMAND 6'h14
`define OFS_STATE 6'h18
// field positions
`define BIT_MON_ENABLE 4
`define BIT_DIR_REVERSE 4
`define BIT_CMD_ABS_CLEAR 0
// status bit layout
`define ST_CMD_ABNORMAL 0
`define ST_SCALE_CONN 1
`define ST_SCALE_STATUS 2
`define ST_SCALE_PHASE 3
`define ST_SCALE_COMM_WARN 4
`define ST_SCALE_ERR_WARN 5
`define ST_ABS_CLEARED 6
`define ST_WIDTH 7
// reset values
`define RST_NET_EXT_SETUP 16'h0000
`define RST_SCALE_CONFIG 5'h00
`define RST_IRQ_MASK 7'h00
// control mode codes
`define MODE_NOP 3'h0
`define MODE_PP 3'h1
`define MODE_CP 3'h2
`define MODE_CV 3'h3
`define MODE_CT 3'h4
// monitor selectors
`define MON_SEL_POS 1'b0
`define MON_SEL_ID 1'b1
`endif

/* File: logic/ext_scale_position_monitor.v */
// external scale position monitor of a servo driver, with abs data clear
// assumes all scale and network inputs share clk_in, except scale_present_in
//
// Implementation choices: the address map and register access over Avalon-MM.
`include "ext_scale_position_monitor_consts.vh"
`default_nettype none
module ext_scale_position_monitor #(
  parameter POS_W = 32
) (
  input wire clk_in,
  input wire rst_n_in,
  // avalon-mm slave
  input wire [5:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  output reg irq_out,
  // network side
  input wire abs_clear_net_in,
  input wire net_reset_cmd_in,
  input wire [POS_W-1:0] abs_position_in,
  output reg [POS_W-1:0] resp_position_out,
  input wire mon_req_in,
  input wire mon_sel_in,
  output reg mon_valid_out,
  output reg mon_refused_out,
  output reg [31:0] mon_data_out,
  input wire fast_cycle_in,
  input wire [2:0] ctrl_mode_in,
  input wire full_closed_in,
  // service link and motion events
  input wire test_run_done_in,
  input wire home_done_in,
  // encoder
  output reg enc_multiturn_clear_out,
  // external scale receiver
  input wire scale_present_in,
  input wire [1:0] attached_scale_type_in,
  input wire scale_pos_valid_in,
  input wire [POS_W-1:0] scale_pos_in,
  input wire [15:0] scale_vendor_id_in,
  input wire [15:0] scale_model_id_in,
  input wire scale_comm_err_in,
  input wire scale_status_err_in,
  input wire scale_phase_err_in,
  // alarm outputs
  output reg command_abnormal_error_out,
  output reg scale_connection_error_out,
  output reg scale_status_errors_out,
  output reg scale_phase_errors_out,
  output reg scale_comm_warning_out,
  output reg scale_error_warning_out
);

////////////////////////////////////////////////////////////////////////////////
// helpers

// true for the semi-closed modes that carry scale functions
function mode_has_scale;
  input [2:0] mode;
  begin
    mode_has_scale = (mode == `MODE_PP) || (mode == `MODE_CP) ||
                     (mode == `MODE_CV) || (mode == `MODE_CT);
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers and state

reg [15:0] network_extended_setup_one; // bit4 monitor enable
reg [4:0] scale_config; // [1:0] scale_type_select, [4] direction reverse
reg [`ST_WIDTH-1:0] irq_status; // sticky events, cleared on read
reg [`ST_WIDTH-1:0] irq_mask; // same layout as status
reg [POS_W-1:0] scale_position_value; // monitored scale position
reg power_cycle_pending; // abs clear done, waits for power cycle
reg present_meta; // synchroniser first stage
reg present_sync; // synchroniser second stage
reg bus_take; // access accepted at the previous edge

wire [1:0] scale_type_select = scale_config[1:0];
wire scale_direction_reverse = scale_config[`BIT_DIR_REVERSE];
wire mon_enable = network_extended_setup_one[`BIT_MON_ENABLE];
wire bus_req = avs_read_in | avs_write_in;
wire wr_take = avs_write_in & ~avs_waitrequest_out;
wire rd_take = avs_read_in & ~avs_waitrequest_out;

// scale functions live: always under full-closed, else bit4 and mode
wire scale_active = full_closed_in |
                    (mon_enable & mode_has_scale(ctrl_mode_in));

// fault conditions, evaluated every cycle
wire cond_cmd_abnormal = mon_enable & fast_cycle_in &
                         (ctrl_mode_in != `MODE_NOP);
wire cond_conn = scale_active & (~present_sync |
                 (attached_scale_type_in != scale_type_select));
wire cond_status = scale_active & scale_status_err_in;
wire cond_phase = scale_active & scale_phase_err_in;
wire cond_comm_warn = scale_active & scale_comm_err_in;
wire cond_err_warn = scale_active & (scale_status_err_in | scale_phase_err_in);

// service-link clear from the command register
wire abs_clear_reg = wr_take & (avs_address_in == `OFS_COMMAND) &
                     avs_writedata_in[`BIT_CMD_ABS_CLEAR];
wire abs_clear_any = abs_clear_reg | abs_clear_net_in;

// events entering status
wire [`ST_WIDTH-1:0] status_set = {abs_clear_any, cond_err_warn, cond_comm_warn,
                                   cond_phase, cond_status, cond_conn,
                                   cond_cmd_abnormal};
wire status_rd = rd_take & (avs_address_in == `OFS_IRQ_STATUS);
// only the bits that software actually saw are cleared: readdata was
// captured one edge before the accept edge, so an event arriving in
// between must survive the read or it would be lost without a trace
wire [`ST_WIDTH-1:0] rd_clear = status_rd ? avs_readdata_out[`ST_WIDTH-1:0] :
                                {`ST_WIDTH{1'b0}};

// scale position after direction reversal only
wire [POS_W-1:0] scale_pos_dir = scale_direction_reverse ?
                                 (~scale_pos_in + {{(POS_W-1){1'b0}}, 1'b1}) :
                                 scale_pos_in;

////////////////////////////////////////////////////////////////////////////////
// scale presence pin synchroniser

always @(posedge clk_in or negedge rst_n_in) begin
  if (!rst_n_in) begin
    present_meta <= 1'b0;
    present_sync <= 1'b0;
  end else begin
    present_meta <= scale_present_in; // first stage only feeds second
    present_sync <= present_meta;
  end
end

////////////////////////////////////////////////////////////////////////////////
// avalon handshake: one wait cycle, then accept
// timing seen by the master:
//   edge e1: request seen with waitrequest high, readdata captured
//   edge e2: waitrequest low, write lands, read data taken
//   edge e3: waitrequest high again, bus_take blocks a re-accept
// the fixed single wait state keeps the read mux off the accept edge

always @(posedge clk_in or negedge rst_n_in) begin
  if (!rst_n_in) begin
    avs_waitrequest_out <= 1'b1;
    bus_take <= 1'b0;
  end else begin
    bus_take <= 1'b0;
    if (bus_req && avs_waitrequest_out && !bus_take) begin
      avs_waitrequest_out <= 1'b0; // answer next edge
    end else begin
      avs_waitrequest_out <= 1'b1; // back to waiting
      bus_take <= ~avs_waitrequest_out;
    end
  end
end

// read data prepared while waitrequest is high
always @(posedge clk_in or negedge rst_n_in) begin
  if (!rst_n_in) begin
    avs_readdata_out <= 32'h00000000;
  end else if (avs_read_in && avs_waitrequest_out) begin
    case (avs_address_in)
      `OFS_NET_EXT_SETUP: avs_readdata_out <= {16'h0000, network_extended_setup_one};
      `OFS_SCALE_CONFIG: avs_readdata_out <= {27'h0000000, scale_config};
      `OFS_IRQ_STATUS: avs_readdata_out <= {25'h0000000, irq_status};
      `OFS_IRQ_MASK: avs_readdata_out <= {25'h0000000, irq_mask};
      `OFS_SCALE_POS: avs_readdata_out <= scale_position_value;
      `OFS_STATE: avs_readdata_out <= {29'h0000000, present_sync, scale_active,
                                       power_cycle_pending};
      default: avs_readdata_out <= 32'h00000000; // unmapped and command read zero
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// software-written registers

always @(posedge clk_in or negedge rst_n_in) begin
  if (!rst_n_in) begin
    network_extended_setup_one <= `RST_NET_EXT_SETUP;
    scale_config <= `RST_SCALE_CONFIG;
    irq_mask <= `RST_IRQ_MASK;
  end else if (wr_take) begin
    case (avs_address_in)
      `OFS_NET_EXT_SETUP: network_extended_setup_one <= avs_writedata_in[15:0];
      `OFS_SCALE_CONFIG: scale_config <= {avs_writedata_in[4], 2'b00,
                                         avs_writedata_in[1:0]};
      `OFS_IRQ_MASK: irq_mask <= avs_writedata_in[`ST_WIDTH-1:0];
      default: ; // others read-only or command
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// sticky status, read clears, a new event in that cycle wins
// level conditions re-set their bit every cycle while they last, so a
// read only quietens the interrupt once the cause has gone away

always @(posedge clk_in or negedge rst_n_in) begin
  if (!rst_n_in) begin
    irq_status <= {`ST_WIDTH{1'b0}};
    irq_out <= 1'b0;
  end else begin
    irq_status <= (irq_status & ~rd_clear) | status_set; // set beats clear
    irq_out <= |(((irq_status & ~rd_clear) | status_set) & irq_mask);
  end
end

////////////////////////////////////////////////////////////////////////////////
// absolute data clear towards the encoder

always @(posedge clk_in or negedge rst_n_in) begin
  if (!rst_n_in) begin
    enc_multiturn_clear_out <= 1'b0;
    power_cycle_pending <= 1'b0;
  end else begin
    enc_multiturn_clear_out <= abs_clear_any;
    if (abs_clear_any) begin
      power_cycle_pending <= 1'b1; // stays until power cycle
    end
  end
end

// response frame position
always @(posedge clk_in or negedge rst_n_in) begin
  if (!rst_n_in) begin
    resp_position_out <= {POS_W{1'b0}};
  end else begin
    resp_position_out <= abs_position_in;
  end
end

////////////////////////////////////////////////////////////////////////////////
// monitored scale position
// only direction reversal is applied; gear, rotation direction and
// home offset belong to the motor side and never reach this value

always @(posedge clk_in or negedge rst_n_in) begin
  if (!rst_n_in) begin
    scale_position_value <= {POS_W{1'b0}}; // power-on init
  end else if (net_reset_cmd_in || test_run_done_in) begin
    scale_position_value <= {POS_W{1'b0}};
  end else if (scale_active && scale_pos_valid_in) begin
    scale_position_value <= scale_pos_dir;
  end
  // home_done_in deliberately has no effect here
end

////////////////////////////////////////////////////////////////////////////////
// monitor and identity command replies, one cycle after request
// a request while scale functions are off is refused, never dropped,
// so the host always sees exactly one answer per request

always @(posedge clk_in or negedge rst_n_in) begin
  if (!rst_n_in) begin
    mon_valid_out <= 1'b0;
    mon_refused_out <= 1'b0;
    mon_data_out <= 32'h00000000;
  end else begin
    mon_valid_out <= mon_req_in & scale_active;
    mon_refused_out <= mon_req_in & ~scale_active;
    if (mon_req_in && scale_active) begin
      if (mon_sel_in == `MON_SEL_ID) begin
        mon_data_out <= {scale_vendor_id_in, scale_model_id_in};
      end else begin
        mon_data_out <= scale_position_value;
      end
    end else if (mon_req_in) begin
      mon_data_out <= 32'h00000000; // refused
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// live alarm outputs
// each output is its condition delayed one edge; latching is left to
// the sticky status bits so alarms clear as soon as the cause goes

always @(posedge clk_in or negedge rst_n_in) begin
  if (!rst_n_in) begin
    command_abnormal_error_out <= 1'b0;
    scale_connection_error_out <= 1'b0;
    scale_status_errors_out <= 1'b0;
    scale_phase_errors_out <= 1'b0;
    scale_comm_warning_out <= 1'b0;
    scale_error_warning_out <= 1'b0;
  end else begin
    command_abnormal_error_out <= cond_cmd_abnormal;
    scale_connection_error_out <= cond_conn;
    scale_status_errors_out <= cond_status;
    scale_phase_errors_out <= cond_phase;
    scale_comm_warning_out <= cond_comm_warn;
    scale_error_warning_out <= cond_err_warn;
  end
end

endmodule
`default_nettype wire

/* File: testbench/ext_scale_position_monitor_sva.sv */
// checker for the scale position monitor: port-level timing relations
// assumes one clock domain, bound to every instance of the top module
`include "ext_scale_position_monitor_consts.vh"
`default_nettype none
module ext_scale_position_monitor_sva #(parameter POS_W = 32) (
  input wire logic clk_in, rst_n_in, avs_read_in, avs_write_in, avs_waitrequest_out,
  input wire logic [5:0] avs_address_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [POS_W-1:0] abs_position_in, resp_position_out,
  input wire logic mon_req_in, mon_valid_out, mon_refused_out,
  input wire logic abs_clear_net_in, enc_multiturn_clear_out, fast_cycle_in,
  input wire logic [2:0] ctrl_mode_in,
  input wire logic full_closed_in, scale_phase_err_in, scale_phase_errors_out,
  input wire logic command_abnormal_error_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic en_q; // shadow of the monitoring enable bit
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////
  // shadow follows accepted writes to the setup register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) en_q <= 1'b0;
    else if (avs_write_in && !avs_waitrequest_out && avs_address_in == `OFS_NET_EXT_SETUP)
      en_q <= avs_writedata_in[`BIT_MON_ENABLE];
  end
  ////////////////////////////////////////////////////////////////
  chk_resp_follows: assert property ($past(rst_n_in) |-> resp_position_out == $past(abs_position_in))
    else $error("response position not one cycle behind");
  chk_clear_pulse: assert property (abs_clear_net_in |=> enc_multiturn_clear_out)
    else $error("multi-turn clear pulse missing");
  chk_mon_answer: assert property (mon_req_in |=> mon_valid_out ^ mon_refused_out)
    else $error("monitor request not answered once");
  chk_mon_quiet: assert property (!mon_req_in |=> !mon_valid_out && !mon_refused_out)
    else $error("monitor answer without request");
  chk_cmd_abn: assert property ($past(rst_n_in) |-> command_abnormal_error_out ==
    $past(fast_cycle_in && en_q && ctrl_mode_in != `MODE_NOP))
    else $error("command abnormal error wrong");
  chk_full_alarm: assert property (full_closed_in && scale_phase_err_in |=> scale_phase_errors_out)
    else $error("full-closed scale alarm missing");
  chk_off_noalarm: assert property (!full_closed_in && !en_q |=> !scale_phase_errors_out)
    else $error("scale alarm while monitoring off");
  chk_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus wait state not exactly one");
  cov_valid: cover property (mon_valid_out);
  cov_refused: cover property (mon_refused_out);
  cov_clear: cover property (enc_multiturn_clear_out);
  cov_abn: cover property (command_abnormal_error_out);
endmodule
bind ext_scale_position_monitor ext_scale_position_monitor_sva #(.POS_W(POS_W)) i_sva (.*);
`default_nettype wire

/* File: testbench/scale_host_model.sv */
// host motion controller model: monitor queries and network pulses
// assumes the bench calls its tasks; signals change after rising edges
`default_nettype none
module scale_host_model (
  input wire logic clk_in,
  output var logic mon_req_in = 1'b0,
  output var logic mon_sel_in = 1'b0,
  output var logic abs_clear_net_in = 1'b0,
  output var logic net_reset_cmd_in = 1'b0,
  input wire logic mon_valid_out,
  input wire logic mon_refused_out,
  input wire logic [31:0] mon_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // one-cycle query, answer taken in the following cycle
  task ask(input logic sel, output logic v, output logic r, output logic [31:0] d);
    @(posedge clk_in); mon_req_in <= 1'b1; mon_sel_in <= sel;
    @(posedge clk_in); mon_req_in <= 1'b0; mon_sel_in <= ~sel;
    @(negedge clk_in); v = mon_valid_out; r = mon_refused_out; d = mon_data_out;
  endtask
  // k 0 clears absolute data, k 1 resets the network
  task pulse(input int k);
    @(posedge clk_in);
    if (k == 0) abs_clear_net_in <= 1'b1;
    else net_reset_cmd_in <= 1'b1;
    @(posedge clk_in); abs_clear_net_in <= 1'b0; net_reset_cmd_in <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: testbench/ext_scale_position_monitor_tb_top.sv */
// self-checking bench of the scale position monitor
// assumes the design, checker and host model are compiled first
`default_nettype none
`define CHK(a, e, m) begin n_compared++; if ((a) !== (e)) begin fails++; \
  $display("[FAIL] %0t %s", $time, m); end end
module ext_scale_position_monitor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, rst_n_in = 0, avs_read_in = 0, avs_write_in = 0, avs_waitrequest_out;
  logic [5:0] avs_address_in = 0;
  logic [31:0] avs_writedata_in = 0, avs_readdata_out, abs_position_in = 32'h0000_0ABC;
  logic [31:0] resp_position_out, mon_data_out, scale_pos_in = 32'h0000_1234, rd;
  logic irq_out, mon_req_in, mon_sel_in, mon_valid_out, mon_refused_out, v, r;
  logic abs_clear_net_in, net_reset_cmd_in, fast_cycle_in = 0, full_closed_in = 0;
  logic [2:0] ctrl_mode_in = `MODE_PP;
  logic test_run_done_in = 0, home_done_in = 0, enc_multiturn_clear_out, scale_present_in = 1;
  logic [1:0] attached_scale_type_in = 0;
  logic scale_pos_valid_in = 1, scale_comm_err_in = 0, scale_status_err_in = 0;
  logic scale_phase_err_in = 0;
  logic [15:0] scale_vendor_id_in = 16'h1A2B, scale_model_id_in = 16'h3C4D; // arbitrary ids
  logic command_abnormal_error_out, scale_connection_error_out, scale_status_errors_out;
  logic scale_phase_errors_out, scale_comm_warning_out, scale_error_warning_out;
  int fails = 0, n_compared = 0;
  ext_scale_position_monitor i_ext_scale_position_monitor (.*);
  scale_host_model i_scale_host_model (.*);
  always #5 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////
  task test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one avalon access, held until waitrequest is seen low
  task bus(input logic w, input logic [5:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_read_in <= !w; avs_write_in <= w; avs_address_in <= a; avs_writedata_in <= wd;
    do begin @(posedge clk_in); n++; end while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50) fails++;
    rd = avs_readdata_out;
    avs_read_in <= 1'b0; avs_write_in <= 1'b0;
  endtask
  task wait_n(input int k); repeat (k) @(posedge clk_in); @(negedge clk_in); endtask
  task t_regs();
    bus(0, `OFS_NET_EXT_SETUP, 0); `CHK(rd, 32'h0, "setup reset")
    bus(1, `OFS_NET_EXT_SETUP, 32'h10); bus(0, `OFS_NET_EXT_SETUP, 0);
    `CHK(rd, 32'h10, "setup readback")
    bus(0, 6'h3C, 0); `CHK(rd, 32'h0, "unmapped read")
    $display("t_regs done");
  endtask
  task t_mon();
    wait_n(3); i_scale_host_model.ask(0, v, r, rd);
    `CHK({v, r, rd}, {2'b10, 32'h1234}, "position query")
    i_scale_host_model.ask(1, v, r, rd);
    `CHK({v, rd}, {1'b1, 32'h1A2B3C4D}, "identity query")
    bus(1, `OFS_SCALE_CONFIG, 32'h10); wait_n(3); i_scale_host_model.ask(0, v, r, rd);
    `CHK(rd, -32'h1234, "reversed position")
    bus(1, `OFS_SCALE_CONFIG, 0); bus(1, `OFS_NET_EXT_SETUP, 0);
    i_scale_host_model.ask(0, v, r, rd); `CHK({v, r}, 2'b01, "refused when off")
    full_closed_in <= 1; i_scale_host_model.ask(0, v, r, rd);
    `CHK({v, r}, 2'b10, "full-closed always")
    full_closed_in <= 0; $display("t_mon done");
  endtask
  task t_pos();
    bus(1, `OFS_NET_EXT_SETUP, 32'h10); ctrl_mode_in <= `MODE_CP; scale_pos_in <= 32'h55;
    wait_n(3); scale_pos_valid_in <= 0;
    @(posedge clk_in); home_done_in <= 1; @(posedge clk_in); home_done_in <= 0;
    bus(0, `OFS_SCALE_POS, 0); `CHK(rd, 32'h55, "kept over homing")
    i_scale_host_model.pulse(1); bus(0, `OFS_SCALE_POS, 0);
    `CHK(rd, 32'h0, "cleared by net reset")
    scale_pos_valid_in <= 1; $display("t_pos done");
  endtask
  task t_clear();
    i_scale_host_model.pulse(0); @(negedge clk_in);
    `CHK(enc_multiturn_clear_out, 1'b1, "clear pulse")
    bus(0, `OFS_STATE, 0); `CHK(rd[0], 1'b1, "power cycle pending")
    bus(0, `OFS_IRQ_STATUS, 0); `CHK(rd[6], 1'b1, "cleared status")
    $display("t_clear done");
  endtask
  task t_fast();
    bus(1, `OFS_IRQ_MASK, 32'h1); fast_cycle_in <= 1; wait_n(2);
    `CHK({command_abnormal_error_out, irq_out}, 2'b11, "fast cycle error")
    ctrl_mode_in <= `MODE_NOP; wait_n(2);
    `CHK(command_abnormal_error_out, 1'b0, "no error in nop")
    fast_cycle_in <= 0; ctrl_mode_in <= `MODE_CV; bus(0, `OFS_IRQ_STATUS, 0);
    `CHK(rd[0], 1'b1, "sticky status")
    wait_n(2); `CHK(irq_out, 1'b0, "irq after read")
    $display("t_fast done");
  endtask
  task t_alarm();
    attached_scale_type_in <= 1; wait_n(3);
    `CHK(scale_connection_error_out, 1'b1, "type mismatch")
    attached_scale_type_in <= 0; scale_present_in <= 0; wait_n(4);
    `CHK(scale_connection_error_out, 1'b1, "scale absent")
    scale_present_in <= 1; scale_phase_err_in <= 1; wait_n(2);
    `CHK(scale_phase_errors_out, 1'b1, "phase alarm")
    bus(1, `OFS_NET_EXT_SETUP, 0); wait_n(2);
    `CHK(scale_phase_errors_out, 1'b0, "alarm off when disabled")
    scale_phase_err_in <= 0; $display("t_alarm done");
  endtask
  task t_extra();
    bus(1, `OFS_NET_EXT_SETUP, 32'h10); ctrl_mode_in <= `MODE_CT;
    scale_status_err_in <= 1; scale_comm_err_in <= 1; wait_n(2);
    `CHK({scale_status_errors_out, scale_comm_warning_out, scale_error_warning_out}, 3'b111, "status and comm alarms")
    scale_status_err_in <= 0; scale_comm_err_in <= 0; scale_pos_in <= 32'h77; wait_n(2);
    scale_pos_valid_in <= 0; bus(0, `OFS_SCALE_POS, 0);
    `CHK(rd, 32'h77, "position in torque mode")
    @(posedge clk_in); test_run_done_in <= 1; @(posedge clk_in); test_run_done_in <= 0;
    bus(0, `OFS_SCALE_POS, 0); `CHK(rd, 32'h0, "cleared by test run")
    scale_pos_valid_in <= 1; bus(1, `OFS_COMMAND, 32'h1); bus(0, `OFS_IRQ_STATUS, 0);
    `CHK(rd[6], 1'b1, "register abs clear")
    $display("t_extra done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1;
    t_regs(); t_mon(); t_pos(); t_clear(); t_fast(); t_alarm(); t_extra();
    test_done();
  end
  initial begin
    #200us;
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
